// ---- pkg/spi_ctrl_map.vh ----
// Register offsets, field positions, reset values and timing figures of the serial controller.
`ifndef SPI_CTRL_MAP_VH
`define SPI_CTRL_MAP_VH

`define ADDR_CTRL 8'hA1
`define ADDR_MODE 8'hA2
`define ADDR_STAT 8'hA3
`define ADDR_DATA 8'hA4
`define ADDR_IRQ_CLR 8'hA6
`define ADDR_IRQ_EN 8'hA7

`define CTRL_IRQ_EN 7
`define CTRL_ENABLE 6
`define CTRL_MASTER 5
`define CTRL_CPOL 4
`define CTRL_CPHA 3
`define CTRL_SAMP_EDGE 2
`define CTRL_RESET 8'h00
`define CTRL_WMASK 8'hFC

`define MODE_THR_HI 7
`define MODE_THR_LO 6
`define MODE_FIFO_CLR 5
`define MODE_RATE_HI 3
`define MODE_RATE_LO 1
`define MODE_MSB_FIRST 0
`define MODE_RESET 8'h00
`define MODE_WMASK 8'hCF

`define STAT_DONE 7
`define STAT_RX_OVR 6
`define STAT_TX_OVR 5
`define STAT_TX_UDR 4
`define STAT_RESET 8'h00
`define IRQ_EN_RESET 4'hF

`define SYS_CLK_MHZ 200
`define RATE_MIN_DIV 6
`define RATE_MIN_HALF 9'h003
`define EDGES_PER_BYTE 5'h10
`define FIFO_DEPTH 4
`define FIFO_AW 2

`endif

// ---- hw/spi_ctrl.v ----
// Serial master/slave controller with four-byte transmit and receive FIFOs.
// Notes on behaviour
// (R1) Separate four-byte transmit and receive FIFOs sit between data register and shifter.
// (R2) Slave select is active low and only honoured in slave mode.
// (R3) Control bit 7 interrupt enable, bit 6 interface enable, bit 5 master select.
// (R4) Serial clock rests high when polarity set, low when clear.
// (R5) Output changes on rising edge when polarity xor phase is one, else falling.
// (R6) Slave samples rising for modes 00 and 11, falling for 01 and 10.
// (R7) Master samples on rising edge when sampling-edge bit set, else falling.
// (R8) Mode bits 7:6 raise the done flag after 1, 2, 3 or 4 bytes.
// (R9) Writing one to mode bit 5 empties both FIFOs.
// (R10) Rate field bits 3:1 divides system clock by 6, 8, 16 up to 512.
// (R11) Mode bit 0 set sends and receives MSB first, clear LSB first.
// (R12) Done flag bit 7 set on transfer end, cleared by writing zero or disabling.
// (R13) Byte arriving into full receive FIFO sets overrun bit 6 and interrupts.
// (R14) Status bits 3:0 show rx full, rx empty, tx full, tx empty, read-only.
// (R15) Data register read pops received data, write pushes transmit data.
// (R16) Mode register and status flag bits 7:4 reset to zero; status reads 05h with both FIFOs empty.
// (R17) Write into full tx FIFO sets bit 5; byte from empty tx FIFO sets bit 4.
// (R18) Interrupt asserts while enabled and done or any error flag is set with its bit set in the interrupt enable register.
`timescale 1ns/1ps
`include "spi_ctrl_map.vh"

module spi_ctrl #(
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW = `FIFO_AW
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe_out,
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe_out,
    input wire miso_in,
    output reg miso_out,
    output reg miso_oe_out,
    input wire slave_select_n_in,
    output reg irq_out
);

    // Half period in system clocks for each rate code.
    function [8:0] half_period;
        input [2:0] code;
        begin
            if (code == 3'h0)
            begin
                half_period = `RATE_MIN_HALF;
            end
            else
            begin
                half_period = 9'h002 << code;
            end
        end
    endfunction

    // Picks the bit that goes out for a given position and order.
    function pick_bit;
        input [7:0] data;
        input [2:0] idx;
        input msb_first;
        begin
            if (msb_first)
            begin
                pick_bit = data[3'h7 - idx];
            end
            else
            begin
                pick_bit = data[idx];
            end
        end
    endfunction

    function [7:0] shift_in;
        input [7:0] data;
        input bit_in;
        input msb_first;
        begin
            if (msb_first)
            begin
                shift_in = {data[6:0], bit_in};
            end
            else
            begin
                shift_in = {bit_in, data[7:1]};
            end
        end
    endfunction

    reg [7:0] ctrl_q;
    reg [7:0] mode_q;
    reg [3:0] flags_q;
    reg [3:0] irq_en_q;
    reg [7:0] tx_mem [0:DEPTH-1];
    reg [7:0] rx_mem [0:DEPTH-1];
    reg [AW-1:0] tx_wp_q;
    reg [AW-1:0] tx_rp_q;
    reg [AW:0] tx_cnt_q;
    reg [AW-1:0] rx_wp_q;
    reg [AW-1:0] rx_rp_q;
    reg [AW:0] rx_cnt_q;
    reg busy_q;
    reg [4:0] edge_cnt_q;
    reg [3:0] sh_cnt_q;
    reg [8:0] div_q;
    reg sck_q;
    reg sck_prev_q;
    reg [7:0] tx_byte_q;
    reg [7:0] rx_sh_q;
    reg [1:0] byte_cnt_q;

    wire enabled = ctrl_q[`CTRL_ENABLE];
    wire is_master = ctrl_q[`CTRL_MASTER];
    wire cpol = ctrl_q[`CTRL_CPOL];
    wire cpha = ctrl_q[`CTRL_CPHA];
    wire msb_first = mode_q[`MODE_MSB_FIRST];
    wire shift_rise = cpol ^ cpha;
    wire [8:0] half = half_period(mode_q[`MODE_RATE_HI:`MODE_RATE_LO]);

    wire wr_ctrl = wr_in && (addr_in == `ADDR_CTRL);
    wire wr_mode = wr_in && (addr_in == `ADDR_MODE);
    wire wr_stat = wr_in && (addr_in == `ADDR_STAT);
    wire wr_data = wr_in && (addr_in == `ADDR_DATA);
    wire wr_clr = wr_in && (addr_in == `ADDR_IRQ_CLR);
    wire wr_ien = wr_in && (addr_in == `ADDR_IRQ_EN);
    wire rd_data = rd_in && (addr_in == `ADDR_DATA);
    wire fifo_clr = wr_mode && wdata_in[`MODE_FIFO_CLR];

    wire tx_full = (tx_cnt_q == DEPTH);
    wire tx_empty = (tx_cnt_q == 0);
    wire rx_full = (rx_cnt_q == DEPTH);
    wire rx_empty = (rx_cnt_q == 0);

    wire slave_sel = enabled && !is_master && !slave_select_n_in; // [R2]
    wire abort = !enabled || (!is_master && slave_select_n_in);
    wire start_m = enabled && is_master && !busy_q && !tx_empty;
    wire start_s = slave_sel && !busy_q;
    wire load = start_m || start_s;
    wire tx_pop = load && !tx_empty && !fifo_clr;
    wire udr_set = start_s && tx_empty; // [R17]

    wire tick = busy_q && is_master && (div_q == half - 9'h001); // [R10]
    wire ev = is_master ? tick : (busy_q && (sck_in != sck_prev_q));
    wire ev_rise = is_master ? !sck_q : sck_in;
    wire shift_ev = ev && (ev_rise == shift_rise); // [R5]
    // Master uses its own sampling edge; a slave samples opposite the shift edge.
    wire samp_ev = ev && (is_master ? (ev_rise == ctrl_q[`CTRL_SAMP_EDGE]) // [R7]
                                    : (ev_rise != shift_rise)); // [R6]
    wire samp_bit = is_master ? miso_in : mosi_in;
    wire [7:0] rx_next = samp_ev ? shift_in(rx_sh_q, samp_bit, msb_first) : rx_sh_q; // [R11]
    wire byte_done = ev && (edge_cnt_q == `EDGES_PER_BYTE - 5'h01) && !abort;
    wire rx_push = byte_done && !rx_full && !fifo_clr;
    wire rx_ovr_set = byte_done && rx_full; // [R13]
    wire tx_push = wr_data && !tx_full && !fifo_clr;
    wire tx_ovr_set = wr_data && tx_full; // [R17]
    wire rx_pop = rd_data && !rx_empty && !fifo_clr;
    wire thr_hit = byte_done && (byte_cnt_q == mode_q[`MODE_THR_HI:`MODE_THR_LO]); // [R8]

    // With phase set the first shift edge presents bit zero, so the index lags by one.
    wire [3:0] idx_raw = (cpha && sh_cnt_q != 4'h0) ? sh_cnt_q - 4'h1 : sh_cnt_q;
    wire [2:0] out_idx = idx_raw[3] ? 3'h7 : idx_raw[2:0];
    wire out_bit = pick_bit(tx_byte_q, out_idx, msb_first); // [R11]

    wire [3:0] flag_set = {thr_hit, rx_ovr_set, tx_ovr_set, udr_set};
    reg [3:0] flags_d;

    always @*
    begin
        flags_d = flags_q;
        if (wr_stat)
        begin
            flags_d = flags_d & wdata_in[7:4]; // [R12] [R13] [R17]
        end
        if (wr_clr)
        begin
            flags_d = flags_d & ~wdata_in[3:0];
        end
        if (!enabled)
        begin
            flags_d[3:2] = 2'h0; // [R12] [R13]
        end
        // An event in the same cycle as its clear is kept.
        flags_d = flags_d | flag_set;
    end

    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_q <= `CTRL_RESET;
            mode_q <= `MODE_RESET; // [R16]
            flags_q <= 4'h0; // [R16]
            irq_en_q <= `IRQ_EN_RESET;
            irq_out <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q <= wdata_in & `CTRL_WMASK; // [R3]
            end
            if (wr_mode)
            begin
                mode_q <= wdata_in & `MODE_WMASK;
            end
            if (wr_ien)
            begin
                irq_en_q <= wdata_in[3:0];
            end
            flags_q <= flags_d;
            irq_out <= ctrl_q[`CTRL_IRQ_EN] && |(flags_q & irq_en_q); // [R18]
        end
    end

    // The FIFO clear takes priority over any push or pop in the same cycle.
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tx_wp_q <= {AW{1'b0}};
            tx_rp_q <= {AW{1'b0}};
            tx_cnt_q <= {(AW+1){1'b0}};
            rx_wp_q <= {AW{1'b0}};
            rx_rp_q <= {AW{1'b0}};
            rx_cnt_q <= {(AW+1){1'b0}};
        end
        else if (fifo_clr)
        begin
            tx_wp_q <= {AW{1'b0}}; // [R9]
            tx_rp_q <= {AW{1'b0}};
            tx_cnt_q <= {(AW+1){1'b0}};
            rx_wp_q <= {AW{1'b0}};
            rx_rp_q <= {AW{1'b0}};
            rx_cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (tx_push)
            begin
                tx_wp_q <= tx_wp_q + {{(AW-1){1'b0}}, 1'b1}; // [R1]
            end
            if (tx_pop)
            begin
                tx_rp_q <= tx_rp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (tx_push && !tx_pop)
            begin
                tx_cnt_q <= tx_cnt_q + {{AW{1'b0}}, 1'b1};
            end
            else if (tx_pop && !tx_push)
            begin
                tx_cnt_q <= tx_cnt_q - {{AW{1'b0}}, 1'b1};
            end
            if (rx_push)
            begin
                rx_wp_q <= rx_wp_q + {{(AW-1){1'b0}}, 1'b1}; // [R1]
            end
            if (rx_pop)
            begin
                rx_rp_q <= rx_rp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (rx_push && !rx_pop)
            begin
                rx_cnt_q <= rx_cnt_q + {{AW{1'b0}}, 1'b1};
            end
            else if (rx_pop && !rx_push)
            begin
                rx_cnt_q <= rx_cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // Storage has no reset; only the pointers define what is valid.
    always @(posedge clk_in)
    begin
        if (tx_push)
        begin
            tx_mem[tx_wp_q] <= wdata_in; // [R15]
        end
        if (rx_push)
        begin
            rx_mem[rx_wp_q] <= rx_next;
        end
    end

    // Byte engine shared by both roles; the edge source differs by role.
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            busy_q <= 1'b0;
            edge_cnt_q <= 5'h00;
            sh_cnt_q <= 4'h0;
            div_q <= 9'h000;
            sck_q <= 1'b0;
            sck_prev_q <= 1'b0;
            tx_byte_q <= 8'h00;
            rx_sh_q <= 8'h00;
            byte_cnt_q <= 2'h0;
        end
        else
        begin
            sck_prev_q <= sck_in;
            if (!enabled)
            begin
                byte_cnt_q <= 2'h0;
            end
            else if (byte_done)
            begin
                byte_cnt_q <= thr_hit ? 2'h0 : byte_cnt_q + 2'h1; // [R8]
            end
            if (busy_q && abort)
            begin
                busy_q <= 1'b0;
                sck_q <= cpol;
            end
            else if (load)
            begin
                busy_q <= 1'b1;
                edge_cnt_q <= 5'h00;
                sh_cnt_q <= 4'h0;
                div_q <= 9'h000;
                rx_sh_q <= 8'h00;
                sck_q <= cpol;
                // A slave with nothing queued sends zeros.
                tx_byte_q <= tx_empty ? 8'h00 : tx_mem[tx_rp_q];
            end
            else if (busy_q)
            begin
                if (is_master)
                begin
                    div_q <= tick ? 9'h000 : div_q + 9'h001;
                    if (tick)
                    begin
                        sck_q <= !sck_q;
                    end
                end
                if (ev)
                begin
                    edge_cnt_q <= edge_cnt_q + 5'h01;
                    rx_sh_q <= rx_next;
                    if (byte_done)
                    begin
                        busy_q <= 1'b0;
                    end
                end
                if (shift_ev)
                begin
                    sh_cnt_q <= sh_cnt_q + 4'h1; // [R5] [R6]
                end
            end
            else
            begin
                sck_q <= cpol; // [R4]
            end
        end
    end

    // Pins are registered, so data moves one system clock after its edge.
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sck_out <= 1'b0;
            sck_oe_out <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe_out <= 1'b0;
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
        end
        else
        begin
            sck_out <= busy_q ? sck_q : cpol; // [R4]
            sck_oe_out <= enabled && is_master;
            mosi_out <= out_bit;
            mosi_oe_out <= enabled && is_master;
            miso_out <= out_bit;
            miso_oe_out <= slave_sel; // [R2]
        end
    end

    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rdata_out <= 8'h00;
        end
        else if (rd_in)
        begin
            case (addr_in)
                `ADDR_CTRL: rdata_out <= ctrl_q;
                `ADDR_MODE: rdata_out <= mode_q;
                `ADDR_STAT: rdata_out <= {flags_q, rx_full, rx_empty, tx_full, tx_empty}; // [R14]
                `ADDR_DATA: rdata_out <= rx_empty ? 8'h00 : rx_mem[rx_rp_q]; // [R15]
                `ADDR_IRQ_EN: rdata_out <= {4'h0, irq_en_q};
                default: rdata_out <= 8'h00;
            endcase
        end
        else
        begin
            rdata_out <= 8'h00;
        end
    end

endmodule

// ---- tb/spi_peer_model.sv ----
// Behavioural serial peer that answers the master with a fixed byte.
`timescale 1ns/1ps
module spi_peer_model (
    input wire logic sck_in,
    input wire logic en_in,
    input wire logic mosi_in,
    input wire logic [7:0] reply_in,
    output logic miso_out,
    output logic [7:0] got_out
);
    integer n = 0;
    initial
    begin
        got_out = 8'h00;
        #1 miso_out = reply_in[7];
    end
    // Clock moves while the controller does not drive the line are not frame edges.
    always @(posedge sck_in)
    begin
        if (en_in)
        begin
            got_out <= {got_out[6:0], mosi_in};
            n = n + 1;
        end
    end
    // The first bit of the next byte goes out at once, since a phase-0 frame samples it first.
    always @(negedge sck_in)
    begin
        if (en_in)
        begin
            if (n >= 8)
                n = 0;
            miso_out <= reply_in[7 - n];
        end
    end
endmodule

// ---- tb/spi_ctrl_checker.sv ----
// Port checker of the serial controller.
`timescale 1ns/1ps
`include "spi_ctrl_map.vh"
module spi_ctrl_checker (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic sck_out,
    input wire logic sck_oe_out,
    input wire logic mosi_oe_out,
    input wire logic miso_oe_out,
    input wire logic slave_select_n_in,
    input wire logic irq_out
);
    reg [7:0] ctrl_q;
    reg [2:0] rate_q;
    wire mapped = addr_in inside {8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA6, 8'hA7};
    // Shadow copies of control and rate, so timing can be tied to what software set.
    always @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_q <= 8'h00;
            rate_q <= 3'h0;
        end
        else if (wr_in && addr_in == `ADDR_CTRL)
            ctrl_q <= wdata_in & 8'hFC;
        else if (wr_in && addr_in == `ADDR_MODE)
            rate_q <= wdata_in[3:1];
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence s_hold;
        $stable(sck_out) [*2];
    endsequence
    sequence s_quiet;
        (!ctrl_q[6] && $stable(ctrl_q)) [*3];
    endsequence
    property p_rd_idle;
        !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
    property p_unmapped;
        rd_in && !mapped |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_read;
        rd_in && addr_in == `ADDR_CTRL |=> rdata_out == ctrl_q;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
    property p_mode_read;
        rd_in && addr_in == `ADDR_MODE |=> rdata_out[5:4] == 2'h0 && rdata_out[3:1] == rate_q;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
    property p_stat_excl;
        rd_in && addr_in == `ADDR_STAT |=> !(rdata_out[3] && rdata_out[2]) && !(rdata_out[1] && rdata_out[0]);
    endproperty
    a_stat_excl: assert property (p_stat_excl) else $error("full and empty together");
    property p_irq_off;
        !ctrl_q[7] |=> !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
    property p_sck_rest;
        s_quiet |-> sck_out == ctrl_q[4];
    endproperty
    a_sck_rest: assert property (p_sck_rest) else $error("clock not at rest level");
    property p_half;
        sck_oe_out && rate_q == 3'h0 && $changed(sck_out) |=> s_hold;
    endproperty
    a_half: assert property (p_half) else $error("clock half period wrong");
    property p_master_oe;
        sck_oe_out |-> mosi_oe_out && !miso_oe_out;
    endproperty
    a_master_oe: assert property (p_master_oe) else $error("master drive enables wrong");
    property p_slave_oe;
        miso_oe_out |-> !$past(slave_select_n_in) && !sck_oe_out;
    endproperty
    a_slave_oe: assert property (p_slave_oe) else $error("slave drives unselected");
endmodule
bind spi_ctrl spi_ctrl_checker chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sck_out(sck_out),
    .sck_oe_out(sck_oe_out), .mosi_oe_out(mosi_oe_out), .miso_oe_out(miso_oe_out),
    .slave_select_n_in(slave_select_n_in), .irq_out(irq_out));

// ---- tb/spi_ctrl_tb.sv ----
// Testbench of the serial controller: registers, flags, slave select and master transfers.
`timescale 1ns/1ps
`include "spi_ctrl_map.vh"
module spi_ctrl_tb;
    reg clk_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg [7:0] addr_in = 8'h00;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg ss_n = 1'b1;
    reg sck_drv = 1'b0;
    reg mosi_drv = 1'b0;
    wire [7:0] rdata_out;
    wire [7:0] got;
    wire sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, irq_out, miso_in;
    integer n_mismatch = 0;
    integer checked = 0;
    integer cyc = 0;
    integer i;
    integer j;
    reg [7:0] v;
    reg [7:0] s = 8'h00;
    integer k;
    always #2.5 clk_in = ~clk_in;
    spi_ctrl uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .sck_in(sck_drv), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .mosi_in(mosi_drv),
        .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out), .miso_in(miso_in),
        .miso_out(miso_out), .miso_oe_out(miso_oe_out), .slave_select_n_in(ss_n),
        .irq_out(irq_out));
    spi_peer_model peer (.sck_in(sck_out), .en_in(sck_oe_out), .mosi_in(mosi_out), .reply_in(8'h3C),
        .miso_out(miso_in), .got_out(got));
    task end_of_test;
    begin
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task chk(input [7:0] g, input [7:0] e);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
    end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
    begin
        rd(a);
        chk(v, e);
    end
    endtask
    // Polling is bounded so that a transfer that never ends shows up as a mismatch.
    task wait_stat(input [7:0] m, input [7:0] e);
    begin
        j = 0;
        rd(`ADDR_STAT);
        while ((v & m) !== e && j < 300)
        begin
            rd(`ADDR_STAT);
            j = j + 1;
        end
        chk(v & m, e);
    end
    endtask
    // One slave frame in mode 0, MSB first; each level is held three clocks for the edge detector.
    task slv_byte(input [7:0] mo);
    begin
        for (k = 0; k < 8; k = k + 1)
        begin
            mosi_drv <= mo[7 - k];
            repeat (3) @(posedge clk_in);
            sck_drv <= 1'b1;
            #1;
            s = {s[6:0], miso_out};
            repeat (3) @(posedge clk_in);
            sck_drv <= 1'b0;
        end
    end
    endtask
    always @(posedge clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rdc(`ADDR_CTRL, 8'h00);
        rdc(`ADDR_MODE, 8'h00);
        rdc(`ADDR_STAT, 8'h05);
        rdc(`ADDR_IRQ_EN, 8'h0F);
        rdc(8'hA5, 8'h00);
        wr(`ADDR_CTRL, 8'h10);
        repeat (4) @(posedge clk_in);
        #1;
        chk({7'h00, sck_out}, 8'h01);
        wr(`ADDR_CTRL, 8'h00);
        $display("test reset done");
        for (i = 0; i < 4; i = i + 1)
            wr(`ADDR_DATA, i[7:0]);
        rdc(`ADDR_STAT, 8'h06);
        wr(`ADDR_DATA, 8'hEE);
        rdc(`ADDR_STAT, 8'h26);
        wr(`ADDR_STAT, 8'h2F);
        rdc(`ADDR_STAT, 8'h26);
        wr(`ADDR_STAT, 8'h00);
        rdc(`ADDR_STAT, 8'h06);
        wr(`ADDR_MODE, 8'h20);
        rdc(`ADDR_STAT, 8'h05);
        rdc(`ADDR_MODE, 8'h00);
        $display("test fifo flags done");
        ss_n <= 1'b0;
        wr(`ADDR_CTRL, 8'h40);
        repeat (3) @(posedge clk_in);
        #1;
        chk({7'h00, miso_oe_out}, 8'h01);
        rdc(`ADDR_STAT, 8'h15);
        ss_n <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk({7'h00, miso_oe_out}, 8'h00);
        wr(`ADDR_CTRL, 8'h00);
        wr(`ADDR_STAT, 8'h00);
        $display("test slave select done");
        wr(`ADDR_MODE, 8'h41);
        wr(`ADDR_DATA, 8'hA5);
        wr(`ADDR_DATA, 8'h5A);
        wr(`ADDR_CTRL, 8'hE4);
        wait_stat(8'h04, 8'h00);
        chk(v & 8'h80, 8'h00);
        wait_stat(8'h80, 8'h80);
        chk(got, 8'h5A);
        chk({7'h00, irq_out}, 8'h01);
        rdc(`ADDR_DATA, 8'h3C);
        rdc(`ADDR_DATA, 8'h3C);
        rdc(`ADDR_STAT, 8'h85);
        wr(`ADDR_STAT, 8'h00);
        rdc(`ADDR_STAT, 8'h05);
        chk({7'h00, irq_out}, 8'h00);
        $display("test master transfer done");
        wr(`ADDR_MODE, 8'hC1);
        for (i = 0; i < 5; i = i + 1)
            wr(`ADDR_DATA, i[7:0]);
        wait_stat(8'h40, 8'h40);
        chk(v, 8'hC9);
        chk({7'h00, irq_out}, 8'h01);
        wr(`ADDR_CTRL, 8'h00);
        rdc(`ADDR_STAT, 8'h09);
        $display("test receive overrun done");
        wr(`ADDR_MODE, 8'h21);
        wr(`ADDR_DATA, 8'h96);
        wr(`ADDR_IRQ_EN, 8'h07);
        ss_n <= 1'b0;
        wr(`ADDR_CTRL, 8'hC0);
        slv_byte(8'hC3);
        @(posedge clk_in);
        ss_n <= 1'b1;
        rdc(`ADDR_STAT, 8'h81);
        chk({7'h00, irq_out}, 8'h00);
        chk(s, 8'h96);
        rdc(`ADDR_DATA, 8'hC3);
        wr(`ADDR_IRQ_EN, 8'h0F);
        rdc(`ADDR_STAT, 8'h85);
        chk({7'h00, irq_out}, 8'h01);
        wr(`ADDR_IRQ_CLR, 8'h08);
        rdc(`ADDR_STAT, 8'h05);
        chk({7'h00, irq_out}, 8'h00);
        wr(`ADDR_CTRL, 8'h00);
        $display("test slave transfer done");
        end_of_test;
    end
endmodule
